// [include/lrb_pkg.sv]
// Purpose: Shared constants and types of the LCD RAM bank serial receiver
// Assumes: Commands carry the continuation flag in bit 7
// Notes: Command prefixes, reset values and display step length live here only
package lrb_pkg;

    // ==========================================================
    // Sizes
    localparam int RAM_DEPTH = 32;
    localparam int RAM_ROWS = 4;
    localparam int PTR_W = 5;
    localparam int SUB_W = 3;
    localparam int BYTE_W = 8;

    // ==========================================================
    // Drive modes and link states
    typedef enum logic [1:0] {MODE_QUAD, MODE_STATIC, MODE_DUAL, MODE_TRI} lrb_mode_t;
    typedef enum logic [1:0] {LNK_IDLE, LNK_RX, LNK_ACK, LNK_IGNORE} lrb_link_st_t;

    // ==========================================================
    // Target address: upper six bits, then the strap bit, then read/write
    localparam logic [5:0] TARGET_ADDR_HI = 6'h1C;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ==========================================================
    // Command byte layout
    localparam int CONT_BIT = 7;
    localparam logic [1:0] CMD_PTR_CODE = 2'h0;
    localparam logic [2:0] CMD_MODE_CODE = 3'h6;
    localparam logic [3:0] CMD_DEV_CODE = 4'hE;
    localparam logic [4:0] CMD_BANK_CODE = 5'h1E;
    localparam int IN_BANK_BIT = 1;
    localparam int OUT_BANK_BIT = 0;

    // ==========================================================
    // Pointer increments per stored byte
    localparam logic [5:0] INC_STATIC = 6'h08;
    localparam logic [5:0] INC_DUAL = 6'h04;
    localparam logic [5:0] INC_TRI = 6'h03;
    localparam logic [5:0] INC_QUAD = 6'h02;

    // ==========================================================
    // Values after reset and display timing
    localparam lrb_mode_t MODE_RESET = MODE_QUAD;
    localparam logic [4:0] PTR_RESET = 5'h00;
    localparam logic [2:0] SUB_RESET = 3'h0;
    localparam logic BANK_RESET = 1'b0;
    localparam int DISPLAY_STEP_CYCLES = 6;

endpackage

// [include/lrb_byte_if.sv]
// Purpose: Carries received bytes from the link domain to the core domain
// Assumes: Data and first flag are stable before the toggle changes
// Notes: Toggle handshake, one change per byte
`timescale 1ns/1ps
interface lrb_byte_if;
    logic tog;
    logic [7:0] data;
    logic first;

    modport link (output tog, output data, output first);
    modport core (input tog, input data, input first);
endinterface

// [design/lrb_sync2.sv]
// Purpose: Two flip-flop synchroniser
// Assumes: Each bit is an independent level
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module lrb_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } lrb_sync_t;

    lrb_sync_t s;
    lrb_sync_t next_s;

    always_comb
    begin
        next_s.meta = d;
        next_s.sync = s.meta;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign q = s.sync;
endmodule

// [design/lrb_link.sv]
// Purpose: Serial bus target receiver on the link sampling clock
// Assumes: Link clock runs free and oversamples the bus lines
// Notes: Forwards every byte after an accepted address byte
`timescale 1ns/1ps
module lrb_link
    import lrb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus lines and strap
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic sa_pin,
    output logic sda_oe,
    // Byte hand-off
    lrb_byte_if.link bus
);
    typedef struct packed {
        lrb_link_st_t st;
        logic scl_d;
        logic sda_d;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic is_addr;
        logic first;
        logic oe;
        logic tog;
        logic [7:0] data;
        logic dfirst;
    } lrb_link_t;

    lrb_link_t s;
    lrb_link_t next_s;
    logic [2:0] pins;
    logic scl_s;
    logic sda_s;
    logic sa_s;
    logic start;
    logic stop;
    logic rise;
    logic fall;

    lrb_sync2 #(.WIDTH(3)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({scl_pin, sda_pin, sa_pin}),
        .q(pins)
    );
    assign {scl_s, sda_s, sa_s} = pins;

    // ==========================================================
    // Conditions and bit engine
    always_comb
    begin
        start = s.scl_d & scl_s & s.sda_d & ~sda_s; // [R13] [R12]
        stop = s.scl_d & scl_s & ~s.sda_d & sda_s; // [R13]
        rise = ~s.scl_d & scl_s;
        fall = s.scl_d & ~scl_s;
        next_s = s;
        next_s.scl_d = scl_s;
        next_s.sda_d = sda_s;
        if (start)
        begin
            next_s.st = LNK_RX;
            next_s.bitcnt = 4'h0;
            next_s.is_addr = 1'b1;
            next_s.oe = 1'b0;
        end
        else if (stop)
        begin
            next_s.st = LNK_IDLE;
            next_s.oe = 1'b0;
        end
        else
        begin
            unique case (s.st)
                LNK_IDLE, LNK_IGNORE:
                begin
                    next_s.oe = 1'b0;
                end
                LNK_RX:
                begin
                    if (rise && s.bitcnt < BITS_PER_BYTE)
                    begin
                        next_s.shreg = {s.shreg[6:0], sda_s};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end
                    else if (fall && s.bitcnt == BITS_PER_BYTE)
                    begin
                        next_s.is_addr = 1'b0;
                        if (s.is_addr)
                        begin
                            if (s.shreg[7:2] == TARGET_ADDR_HI && s.shreg[1] == sa_s
                                && !s.shreg[0]) // [R18] [R17]
                            begin
                                next_s.oe = 1'b1;
                                next_s.st = LNK_ACK;
                                next_s.first = 1'b1;
                            end
                            else
                                next_s.st = LNK_IGNORE;
                        end
                        else
                        begin
                            next_s.data = s.shreg;
                            next_s.dfirst = s.first;
                            next_s.first = 1'b0;
                            next_s.tog = ~s.tog;
                            next_s.oe = 1'b1; // [R16] [R15]
                            next_s.st = LNK_ACK;
                        end
                    end
                end
                LNK_ACK:
                begin
                    if (fall)
                    begin
                        next_s.oe = 1'b0;
                        next_s.st = LNK_RX;
                        next_s.bitcnt = 4'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '{st: LNK_IDLE, default: '0};
        else
            s <= next_s;
    end

    assign sda_oe = s.oe;
    assign bus.tog = s.tog;
    assign bus.data = s.data;
    assign bus.first = s.dfirst;

    // ==========================================================
    // Checks
    chk_ack_hold_high: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
        (s.oe && !fall && !start && !stop) |=> s.oe)
        else $error("acknowledge released before clock fall");
    chk_start_restart: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        start |=> (s.st == LNK_RX && s.bitcnt == 4'h0 && !s.oe))
        else $error("start condition not taken");
    chk_drive_only_ack: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
        (s.st != LNK_ACK) |-> !s.oe)
        else $error("data line driven outside acknowledge");
endmodule

// [design/lrb_top.sv]
// Purpose: Write path and row selection of a 32 x 4 segment display driver
// Assumes: Link clock oversamples the serial lines; straps are static
// Notes: Backplane outputs are logic levels of the active step, no waveforms
//
// Summary of operation
// (R1) Controller reloads pointer to prior byte's last column; new top bits overwrite
// (R2) Output bank selector picks one row per address by mode and step
// (R3) Four-row mode shows row 0, then rows 1, 2 and 3
// (R4) Three-row mode shows rows 0, 1, 2 and never row 3
// (R5) Two-row mode shows rows 0 and 1; static shows row 0
// (R6) Static mode with alternate output bank shows row 2
// (R7) Two-row mode with alternate output bank shows rows 2 and 3
// (R8) Alternate input bank writes row 2 static, rows 2 and 3 two-row
// (R9) Input and output bank selections held and changed independently
// (R10) Exactly banks 0 and 1, both set by bank-select command
// (R11) Bank switching acts only in static and two-row modes
// (R12) Controller keeps data steady while clock is high
// (R13) Data fall with clock high is start, data rise is stop
// (R14) Controller starts only with both lines released high
// (R15) Every byte is followed by an acknowledge; any byte count allowed
// (R16) Addressed device holds data low through acknowledge clock high
// (R17) Device is receive-only target; its only drive is acknowledge
// (R18) Selection uses target address, command data and hardware subaddress
// (R19) Three subaddress pins form a binary value, zero when all low
// (R20) Three-row mode advances pointer by three per stored byte
// (R21) Store only when subaddress counter matches; pointer advances anyway
// (R22) Command with bit 7 clear is last; following bytes are display data
// (R23) Each bank selection is one bit, zero at reset, set by command
`timescale 1ns/1ps
module lrb_top
    import lrb_pkg::*;
#(
    parameter int STEP_CYCLES = DISPLAY_STEP_CYCLES
) (
    // Clocks and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic LINK_CLK,
    // Serial bus
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Straps
    input wire logic TARGET_SA,
    input wire logic HW_SUBADDR_BIT0,
    input wire logic HW_SUBADDR_BIT1,
    input wire logic HW_SUBADDR_BIT2,
    // Display drive
    output logic BACKPLANE_OUT_0,
    output logic BACKPLANE_OUT_1,
    output logic BACKPLANE_OUT_2,
    output logic BACKPLANE_OUT_3,
    output logic [31:0] SEGMENT_OUT,
    // Status
    output lrb_pkg::lrb_mode_t DRIVE_MODE,
    output logic INPUT_BANK,
    output logic OUTPUT_BANK,
    output logic [4:0] DATA_POINTER,
    output logic [2:0] SUBADDR_COUNT
);
    import lrb_pkg::*;

    typedef struct packed {
        logic tog_d;
        logic cmd_phase;
        lrb_mode_t mode;
        logic in_bank;
        logic out_bank;
        logic [PTR_W-1:0] ptr;
        logic [SUB_W-1:0] sub;
        logic [RAM_DEPTH-1:0][RAM_ROWS-1:0] ram;
        logic [1:0] step;
        logic [7:0] cyc;
        logic [RAM_DEPTH-1:0] seg;
        logic [RAM_ROWS-1:0] bp;
        logic sda_low;
    } lrb_core_t;

    localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

    lrb_core_t s;
    lrb_core_t next_s;
    lrb_byte_if byte_bus ();
    logic tog_s;
    logic [2:0] hw_sub;
    logic evt;
    logic cmd_now;
    logic data_evt;
    logic bank_cmd;
    logic store_ok;
    logic [7:0] rx;
    logic [5:0] inc;
    logic [5:0] sum;
    logic [1:0] last_step;
    logic [1:0] row_sel;

    // ==========================================================
    // Link domain receiver and crossings
    lrb_link u_link (
        .clk(LINK_CLK),
        .rst_n(RESET_N),
        .scl_pin(SCL),
        .sda_pin(SDA_IN),
        .sa_pin(TARGET_SA),
        .sda_oe(SDA_OE),
        .bus(byte_bus)
    );

    lrb_sync2 #(.WIDTH(1)) u_tog_sync (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .d(byte_bus.tog),
        .q(tog_s)
    );

    lrb_sync2 #(.WIDTH(3)) u_sub_sync (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .d({HW_SUBADDR_BIT2, HW_SUBADDR_BIT1, HW_SUBADDR_BIT0}), // [R19]
        .q(hw_sub)
    );

    // ==========================================================
    // Byte decode, pointer and RAM write
    always_comb
    begin
        int off;
        int row;
        off = 0;
        row = 0;
        next_s = s;
        rx = byte_bus.data;
        evt = tog_s ^ s.tog_d;
        next_s.tog_d = tog_s;
        cmd_now = evt && (byte_bus.first || s.cmd_phase);
        data_evt = evt && !cmd_now;
        bank_cmd = 1'b0;
        store_ok = (s.sub == hw_sub); // [R21] [R18]
        unique case (s.mode)
            MODE_STATIC: inc = INC_STATIC;
            MODE_DUAL: inc = INC_DUAL;
            MODE_TRI: inc = INC_TRI; // [R20]
            MODE_QUAD: inc = INC_QUAD;
        endcase
        sum = {1'b0, s.ptr} + inc;
        if (cmd_now)
        begin
            next_s.cmd_phase = rx[CONT_BIT]; // [R22]
            if (rx[6:5] == CMD_PTR_CODE)
                next_s.ptr = rx[4:0]; // [R1]
            else if (rx[6:4] == CMD_MODE_CODE)
                next_s.mode = lrb_mode_t'(rx[1:0]);
            else if (rx[6:3] == CMD_DEV_CODE)
                next_s.sub = rx[2:0];
            else if (rx[6:2] == CMD_BANK_CODE)
            begin
                bank_cmd = 1'b1;
                next_s.in_bank = rx[IN_BANK_BIT]; // [R9] [R10] [R23]
                next_s.out_bank = rx[OUT_BANK_BIT]; // [R9] [R10] [R23]
            end
        end
        if (data_evt)
        begin
            next_s.ptr = sum[4:0]; // [R21]
            if (sum[5])
                next_s.sub = s.sub + 3'h1;
            if (store_ok)
            begin
                for (int i = 0; i < 8; i++)
                begin
                    unique case (s.mode)
                        MODE_STATIC:
                        begin
                            off = i;
                            row = s.in_bank ? 2 : 0; // [R8] [R11]
                        end
                        MODE_DUAL:
                        begin
                            off = i / 2;
                            row = (i % 2) + (s.in_bank ? 2 : 0); // [R8] [R11]
                        end
                        MODE_TRI:
                        begin
                            off = i / 3;
                            row = i % 3; // [R1]
                        end
                        MODE_QUAD:
                        begin
                            off = i / 4;
                            row = i % 4;
                        end
                    endcase
                    if ((int'(s.ptr) + off) < RAM_DEPTH)
                        next_s.ram[5'(int'(s.ptr) + off)][2'(row)] = rx[7 - i];
                end
            end
        end

        // Row selection and multiplex stepping
        unique case (s.mode)
            MODE_STATIC:
            begin
                last_step = 2'h0;
                row_sel = {s.out_bank, 1'b0}; // [R5] [R6] [R11]
                next_s.bp = 4'hF;
            end
            MODE_DUAL:
            begin
                last_step = 2'h1;
                row_sel = {s.out_bank, s.step[0]}; // [R5] [R7] [R11]
                next_s.bp = {s.step[0], ~s.step[0], s.step[0], ~s.step[0]};
            end
            MODE_TRI:
            begin
                last_step = 2'h2;
                row_sel = (s.step == 2'h3) ? 2'h0 : s.step; // [R4]
                next_s.bp = {s.step == 2'h1, s.step == 2'h2, s.step == 2'h1, s.step == 2'h0};
            end
            MODE_QUAD:
            begin
                last_step = 2'h3;
                row_sel = s.step; // [R3]
                next_s.bp = 4'h1 << s.step;
            end
        endcase
        for (int a = 0; a < RAM_DEPTH; a++)
            next_s.seg[a] = s.ram[a][row_sel]; // [R2]
        if (s.cyc >= STEP_LAST)
        begin
            next_s.cyc = 8'h00;
            next_s.step = (s.step >= last_step) ? 2'h0 : s.step + 2'h1; // [R3] [R4]
        end
        else
            next_s.cyc = s.cyc + 8'h01;
        next_s.sda_low = 1'b0;
    end

    always_ff @(posedge REF_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s <= '0;
            s.mode <= MODE_RESET;
            s.ptr <= PTR_RESET;
            s.sub <= SUB_RESET;
            s.in_bank <= BANK_RESET; // [R23]
            s.out_bank <= BANK_RESET; // [R23]
        end
        else
            s <= next_s;
    end

    // ==========================================================
    // Outputs
    assign SDA_OUT = s.sda_low;
    assign BACKPLANE_OUT_0 = s.bp[0];
    assign BACKPLANE_OUT_1 = s.bp[1];
    assign BACKPLANE_OUT_2 = s.bp[2];
    assign BACKPLANE_OUT_3 = s.bp[3];
    assign SEGMENT_OUT = s.seg;
    assign DRIVE_MODE = s.mode;
    assign INPUT_BANK = s.in_bank;
    assign OUTPUT_BANK = s.out_bank;
    assign DATA_POINTER = s.ptr;
    assign SUBADDR_COUNT = s.sub;

    // ==========================================================
    // Checks
    chk_tri_no_row3: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [R4]
        (s.mode == MODE_TRI) |-> (row_sel != 2'h3))
        else $error("row 3 shown in three-row mode");
    chk_quad_row_order: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [R3]
        (s.mode == MODE_QUAD && s.step == 2'h1 && s.cyc == STEP_LAST && !cmd_now)
        |=> (s.step == 2'h2))
        else $error("four-row sequence out of order");
    chk_static_bank_row: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [R6]
        (s.mode == MODE_STATIC) |-> (row_sel == {s.out_bank, 1'b0}))
        else $error("static row does not follow output bank");
    chk_dual_bank_rows: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [R7]
        (s.mode == MODE_DUAL) |-> (row_sel[1] == s.out_bank && row_sel[0] == s.step[0]))
        else $error("two-row selection does not follow output bank");
    chk_tri_ptr_step: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [R20]
        (data_evt && s.mode == MODE_TRI) |=> (s.ptr == $past(s.ptr) + 5'h03))
        else $error("pointer did not advance by three");
    chk_store_gated: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [R21]
        (data_evt && !store_ok) |=> (s.ram == $past(s.ram) && s.ptr != $past(s.ptr)))
        else $error("store not suppressed or pointer held");
    chk_bank_hold: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [R23]
        !bank_cmd |=> ($stable(s.in_bank) && $stable(s.out_bank)))
        else $error("bank changed without bank command");
    chk_last_cmd_data: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // [R22]
        (cmd_now && !rx[CONT_BIT]) |=> !s.cmd_phase)
        else $error("data phase not entered after last command");
endmodule

// [test/lrb_i2c_ctl.sv]
// Purpose: Serial bus controller model driving clock and data toward the receiver
// Assumes: Data line is open drain with a pull-up resolved by the bench
// Notes: Half bit period is HALF_NS; clock stands high while the bus is idle
`timescale 1ns/1ps
module lrb_i2c_ctl #(
    parameter int HALF_NS = 1000
) (
    // Resolved data line
    input wire logic sda_line,
    // Controller drive
    output logic scl,
    output logic sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // ==========
    // Start, also as a repeated start; first one only from an idle bus
    task automatic start();
        sda_low = 1'b0;
        #HALF_NS scl = 1'b1;
        #HALF_NS sda_low = 1'b1;
        #HALF_NS scl = 1'b0;
    endtask

    // ==========
    // Byte MSB first, data moved only while the clock is low, then the acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #(HALF_NS / 2) sda_low = ~b[i];
            #(HALF_NS / 2) scl = 1'b1;
            #HALF_NS scl = 1'b0;
        end
        #(HALF_NS / 2) sda_low = 1'b0;
        #(HALF_NS / 2) scl = 1'b1;
        #(HALF_NS / 2) ack = (sda_line === 1'b0);
        #(HALF_NS / 2) scl = 1'b0;
    endtask

    // ==========
    // Stop: data rises while the clock is high
    task automatic stop();
        #(HALF_NS / 2) sda_low = 1'b1;
        #(HALF_NS / 2) scl = 1'b1;
        #HALF_NS sda_low = 1'b0;
        #HALF_NS;
    endtask
endmodule

// [test/tb_lrb_top.sv]
// Purpose: Self-checking bench of the display RAM bank receiver
// Assumes: Straps are static for the whole run
// Notes: Status after each acknowledged byte is compared through a queue
`timescale 1ns/1ps
module tb_lrb_top;
    import lrb_pkg::*;
    localparam int STEP = 2;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic sa;
    logic [2:0] hw;
    wire logic scl;
    wire logic ctl_low;
    wire logic sda_out;
    wire logic sda_oe;
    wire logic sda_line = !(ctl_low || (sda_oe && !sda_out));
    wire logic [3:0] bp;
    wire logic [31:0] seg;
    lrb_mode_t mode;
    wire logic ib;
    wire logic ob;
    wire logic [4:0] ptr;
    wire logic [2:0] sub;
    wire logic [11:0] stat = {mode, ib, ob, ptr, sub};
    logic [11:0] exp_q[$];
    lrb_mode_t e_mode;
    lrb_mode_t mlist[3] = '{MODE_DUAL, MODE_TRI, MODE_QUAD};
    logic e_ib;
    logic e_ob;
    logic [4:0] e_ptr;
    logic [2:0] e_sub;
    logic [31:0] row0;
    logic [31:0] row2;
    logic [31:0] rng;
    int n_errors = 0;
    int cmp_count = 0;

    always #50 ref_clk = ~ref_clk;
    always #32 link_clk = ~link_clk;

    lrb_top #(.STEP_CYCLES(STEP)) u_dut (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .LINK_CLK(link_clk), .SCL(scl),
        .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TARGET_SA(sa),
        .HW_SUBADDR_BIT0(hw[0]), .HW_SUBADDR_BIT1(hw[1]), .HW_SUBADDR_BIT2(hw[2]),
        .BACKPLANE_OUT_0(bp[0]), .BACKPLANE_OUT_1(bp[1]), .BACKPLANE_OUT_2(bp[2]),
        .BACKPLANE_OUT_3(bp[3]), .SEGMENT_OUT(seg), .DRIVE_MODE(mode),
        .INPUT_BANK(ib), .OUTPUT_BANK(ob), .DATA_POINTER(ptr), .SUBADDR_COUNT(sub)
    );

    lrb_i2c_ctl #(.HALF_NS(1000)) u_ctl (.sda_line(sda_line), .scl(scl), .sda_low(ctl_low));

    // ==========
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [3:0] bp_next(input logic [3:0] p, input lrb_mode_t m);
        case (m)
            MODE_QUAD: return {p[2:0], p[3]};
            MODE_TRI: return (p == 4'h1) ? 4'hA : (p == 4'hA) ? 4'h4 : 4'h1;
            MODE_DUAL: return ~p;
            default: return 4'hF;
        endcase
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ==========
    // Bus transfers with expected status noted per acknowledged byte
    task automatic put(input logic [7:0] b, input logic exp);
        logic ack;
        if (exp)
            exp_q.push_back({e_mode, e_ib, e_ob, e_ptr, e_sub});
        u_ctl.send_byte(b, ack);
        check(32'(ack), 32'(exp), "ack");
    endtask

    task automatic adr(input logic s, input logic rd, input logic exp);
        u_ctl.start();
        put({TARGET_ADDR_HI, s, rd}, exp);
    endtask

    task automatic cmd(input logic [7:0] b);
        if (b[6:5] == CMD_PTR_CODE)
            e_ptr = b[4:0];
        else if (b[6:4] == CMD_MODE_CODE)
            e_mode = lrb_mode_t'(b[1:0]);
        else if (b[6:3] == CMD_DEV_CODE)
            e_sub = b[2:0];
        else if (b[6:2] == CMD_BANK_CODE)
            {e_ib, e_ob} = b[1:0];
        put(b, 1'b1);
    endtask

    task automatic dat(input logic [7:0] b);
        logic [5:0] inc;
        logic [5:0] sum;
        int a;
        inc = (e_mode == MODE_STATIC) ? INC_STATIC : (e_mode == MODE_DUAL) ? INC_DUAL
            : (e_mode == MODE_TRI) ? INC_TRI : INC_QUAD;
        for (int i = 0; i < 8; i++)
        begin
            a = int'(e_ptr) + i;
            if (e_mode == MODE_STATIC && e_sub === hw && a < 32 && e_ib)
                row2[a] = b[7 - i];
            else if (e_mode == MODE_STATIC && e_sub === hw && a < 32)
                row0[a] = b[7 - i];
        end
        sum = {1'b0, e_ptr} + inc;
        e_ptr = sum[4:0];
        e_sub = e_sub + {2'h0, sum[5]};
        put(b, 1'b1);
    endtask

    task automatic wait_seg(input logic [31:0] e);
        for (int w = 0; w < 50 && seg !== e; w++)
            @(posedge ref_clk);
        check(seg, e, "segments");
    endtask

    task automatic bp_seq();
        logic [3:0] prev;
        prev = bp;
        repeat (8 * STEP)
        begin
            @(posedge ref_clk);
            #1;
            if (bp !== prev)
                check(32'(bp), 32'(bp_next(prev, e_mode)), "backplanes");
            prev = bp;
        end
    endtask

    // ==========
    // Result watcher: each end of acknowledge takes the oldest note
    always @(negedge sda_oe)
    begin
        if (reset_n === 1'b1 && exp_q.size() == 0)
            check(32'h1, 32'h0, "spare ack");
        else if (reset_n === 1'b1)
            check(32'(stat), 32'(exp_q.pop_front()), "status");
    end

    // ==========
    // Main sequence
    initial
    begin
        rng = xs(32'h00015C56);
        sa = rng[0];
        hw = rng[3:1];
        row0 = 32'h0;
        row2 = 32'h0;
        e_mode = MODE_RESET;
        e_ib = BANK_RESET;
        e_ob = BANK_RESET;
        e_ptr = PTR_RESET;
        e_sub = SUB_RESET;
        repeat (20) @(posedge ref_clk);
        #5 reset_n = 1'b1;
        repeat (10) @(posedge ref_clk);
        check(32'(stat), 32'({e_mode, e_ib, e_ob, e_ptr, e_sub}), "reset");
        check(32'(sda_out), 32'h0, "data drive level");
        // Refused: other strap value, then a read request
        adr(~sa, 1'b0, 1'b0);
        put(8'hE1, 1'b0);
        u_ctl.stop();
        adr(sa, 1'b1, 1'b0);
        u_ctl.stop();
        // Static mode: assemble in bank 1, show bank 0, then switch
        rng = xs(rng);
        adr(sa, 1'b0, 1'b1);
        cmd(8'hE1);
        cmd({5'h1E, hw});
        cmd(8'hFA);
        cmd(8'h18);
        dat(rng[7:0]);
        adr(sa, 1'b0, 1'b1);
        cmd({5'h1E, hw});
        cmd(8'hF8);
        cmd(8'h18);
        dat(rng[15:8]);
        dat(rng[23:16]);
        u_ctl.stop();
        wait_seg(row0);
        check(32'(bp), 32'hF, "static backplanes");
        adr(sa, 1'b0, 1'b1);
        cmd(8'h79);
        u_ctl.stop();
        wait_seg(row2);
        // Multiplexed modes: pointer steps and row order
        for (int k = 0; k < 3; k++)
        begin
            rng = xs(rng);
            adr(sa, 1'b0, 1'b1);
            cmd({6'h38, mlist[k]});
            cmd(8'h05);
            dat(rng[7:0]);
            dat(rng[15:8]);
            u_ctl.stop();
            bp_seq();
        end
        for (int w = 0; w < 100 && exp_q.size() != 0; w++)
            @(posedge ref_clk);
        if (exp_q.size() != 0)
            check(32'h1, 32'h0, "pending status");
        summarize();
    end
endmodule
